// ### shared/mcs_pkg.sv
// Purpose: Shared constants and carrier types of the monitor conversion scheduler
// Assumes: 32-bit classic Wishbone, register index times four gives the byte address
// Notes:   All timing counts derive from the clock rate below
package mcs_pkg;
    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [5:0] IDX_CMD  = 6'h00;
    localparam logic [5:0] IDX_RES  = 6'h01;
    localparam logic [5:0] IDX_T1   = 6'h02;
    localparam logic [5:0] IDX_T2   = 6'h03;
    localparam logic [5:0] IDX_TI   = 6'h04;
    localparam logic [5:0] IDX_SEQ  = 6'h08;
    localparam logic [5:0] IDX_CFG  = 6'h09;
    localparam logic [5:0] IDX_PD   = 6'h0A;
    localparam logic [5:0] IDX_OFS1 = 6'h26;
    localparam logic [5:0] IDX_OFS2 = 6'h27;
    localparam logic [5:0] IDX_IST  = 6'h30;
    localparam logic [5:0] IDX_IMSK = 6'h31;
    localparam logic [5:0] IDX_OCL  = 6'h32;
    localparam logic [5:0] IDX_STAT = 6'h33;
    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int         CFG_AUTO_BIT = 0;
    localparam int         PD_ADC_REF   = 4;
    localparam int         PD_DAC_REF   = 5;
    localparam logic [7:0] PD_RST       = 8'h30;
    localparam logic [11:0] DAC_RST     = 12'hFFF;
    localparam int         IRQ_TEMP     = 0;
    localparam int         IRQ_RES      = 1;
    localparam int         IRQ_OC0      = 2;
    localparam logic [3:0] CH_TEMP0     = 4'h6;
    localparam logic [3:0] CH_TINT      = 4'h8;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ         = 10_000_000;
    localparam int PERIOD_MS      = 5;
    localparam int REF_SETTLE_US  = 60;
    localparam int PERIOD_CYC     = PERIOD_MS * (CLK_HZ / 1000);
    localparam int REF_SETTLE_CYC = (REF_SETTLE_US * CLK_HZ + 999_999) / 1_000_000;

    typedef struct packed {
        logic       start;
        logic [3:0] chan;
    } mcs_conv_req_t;
endpackage : mcs_pkg

// ### design/mcs_integ.sv
// Purpose: Background integration timer, one channel per slot in turn
// Assumes: Single clock, SLOT_CYC at least 2
// Notes:   Emits a one-cycle done pulse for the channel whose slot ends
`timescale 1ns/100ps
module mcs_integ #(
    parameter int SLOT_CYC = 16666
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    output logic      [2:0] o_done
);
    localparam int CW = $clog2(SLOT_CYC);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [1:0]    slot;
        logic [2:0]    done;
    } mcs_integ_state_t;

    mcs_integ_state_t s;
    mcs_integ_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 3'h0;
        if (s.cnt == CW'(SLOT_CYC - 1)) begin
            next_s.cnt = '0;
            next_s.done[s.slot] = 1'b1;
            next_s.slot = (s.slot == 2'h2) ? 2'h0 : s.slot + 2'h1;
        end else begin
            next_s.cnt = s.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_done = s.done;

    chk_done_onehot: assert property (@(posedge i_clk) disable iff (i_reset) $onehot0(o_done))
        else $error("Two integration slots ended together");
endmodule : mcs_integ

// ### design/mcs_top.sv
// Purpose: Conversion scheduler, temperature results, overcurrent latch, DAC codes
// Assumes: Converter core on i_clk answers a start with a one-cycle done
// Notes:   Registers over classic Wishbone, one word per register index
// Overview of operation
// - Each temperature channel gets a fresh result every 5 ms without host action.
// - An integration end raises a conversion request for that channel.
// - In command mode a pending request runs right after the current conversion.
// - In autocycle mode a pending request is slotted into the running sequence.
// - With the converter idle a pending request starts at once.
// - Three temperature result registers hold the latest results, readable anytime.
// - Command mode may return remote temperature registers within the read-out sequence.
// - Remote channel offset is added to each remote channel measurement before storing.
// - Overcurrent flag output rises when its comparator reports over threshold.
// - Each 12-bit DAC code is inverted before selecting the string tap.
// - References start external; clearing power-down bits 4 and 5 enables internal.
// - Overcurrent flag stays high until the host clears its latch.
// - Remote temperature command bits start no conversion; latest result is returned.
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module mcs_top #(
    parameter int PERIOD_CYC = mcs_pkg::PERIOD_CYC
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [7:0]            i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    output logic      [31:0]           o_wb_dat,
    output logic                       o_wb_ack,
    input  wire logic [1:0]            i_oc_cmp,
    output logic      [1:0]            o_overcurrent_flag_out,
    output mcs_pkg::mcs_conv_req_t     o_conv,
    input  wire logic                  i_conv_done,
    input  wire logic [11:0]           i_conv_data,
    output logic      [3:0][11:0]      o_dac_tap,
    output logic                       o_int_ref_adc_en,
    output logic                       o_int_ref_dac_en,
    output logic                       o_ref_ready,
    output logic                       o_irq
);
    // ****************************************
    // State
    // ****************************************
    typedef enum logic {CV_IDLE, CV_BUSY} mcs_cv_t;

    typedef struct packed {
        logic [1:0]       sync1;
        logic [1:0]       sync2;
        logic [1:0]       oc;
        logic             ack;
        logic [31:0]      rdat;
        logic [7:0]       cmd;
        logic [5:0]       seqm;
        logic [7:0]       cfg;
        logic [7:0]       pd;
        logic [1:0][11:0] ofs;
        logic [3:0][11:0] dac;
        logic [2:0][11:0] temp;
        logic [15:0]      res;
        logic [2:0]       pend;
        mcs_cv_t          cst;
        logic [3:0]       cur;
        logic [2:0]       ptr;
        logic             cmd_mode;
        logic             wait_rd;
        logic [3:0]       ist;
        logic [3:0]       imsk;
        logic             irq;
        logic [9:0]       ref_cnt;
        logic             ref_rdy;
        logic [1:0]       ref_en;
        logic             start;
    } mcs_top_state_t;

    mcs_top_state_t s;
    mcs_top_state_t next_s;
    logic [2:0]     integ_done;
    logic           acc;
    logic           wr;
    logic           rd;
    logic [5:0]     idx;
    logic [15:0]    wd;
    logic [1:0]     oc_clr;

    mcs_integ #(.SLOT_CYC(PERIOD_CYC / 3)) u_integ (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .o_done  (integ_done)
    );

    // Cyclic search for the next selected channel at or after p
    function automatic logic [3:0] mcs_next(input logic [7:0] m, input logic [2:0] p);
        logic [3:0] r;
        logic [2:0] k;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            k = p + 3'(i);
            if (m[k]) begin
                r = {1'b1, k};
            end
        end
        return r;
    endfunction : mcs_next

    assign acc    = i_wb_cyc & i_wb_stb & ~s.ack;
    assign wr     = acc & i_wb_we;
    assign rd     = acc & ~i_wb_we;
    assign idx    = i_wb_adr[7:2];
    assign wd     = i_wb_dat[15:0];
    assign oc_clr = (wr && idx == mcs_pkg::IDX_OCL && i_wb_sel[0]) ? wd[1:0] : 2'h0;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [3:0] nx;
        logic [1:0] t;
        nx = 4'h0;
        t = 2'h0;
        next_s = s;
        next_s.ack = acc;
        next_s.start = 1'b0;
        next_s.sync1 = i_oc_cmp;
        next_s.sync2 = s.sync1;

        if (wr) begin
            case (idx)
                mcs_pkg::IDX_CMD: begin
                    next_s.cmd = wd[7:0];
                    next_s.cmd_mode = 1'b1;
                    next_s.ptr = 3'h0;
                    next_s.wait_rd = 1'b0;
                end
                mcs_pkg::IDX_RES, mcs_pkg::IDX_T1, mcs_pkg::IDX_T2, mcs_pkg::IDX_TI: begin
                    if (i_wb_sel[1:0] == 2'h3) begin
                        next_s.dac[2'(idx - mcs_pkg::IDX_RES)] = ~wd[11:0];
                    end
                end
                mcs_pkg::IDX_SEQ:  if (i_wb_sel[0]) next_s.seqm = wd[5:0];
                mcs_pkg::IDX_CFG:  if (i_wb_sel[0]) next_s.cfg = wd[7:0];
                mcs_pkg::IDX_PD:   if (i_wb_sel[0]) next_s.pd = wd[7:0];
                mcs_pkg::IDX_OFS1: if (i_wb_sel[1:0] == 2'h3) next_s.ofs[0] = wd[11:0];
                mcs_pkg::IDX_OFS2: if (i_wb_sel[1:0] == 2'h3) next_s.ofs[1] = wd[11:0];
                mcs_pkg::IDX_IST:  if (i_wb_sel[0]) next_s.ist = s.ist & ~wd[3:0];
                mcs_pkg::IDX_IMSK: if (i_wb_sel[0]) next_s.imsk = wd[3:0];
                default: begin
                end
            endcase
        end

        next_s.rdat = 32'h0;
        if (rd) begin
            case (idx)
                mcs_pkg::IDX_CMD:  next_s.rdat = {24'h0, s.cmd};
                mcs_pkg::IDX_RES: begin
                    next_s.rdat = {16'h0, s.res};
                    next_s.wait_rd = 1'b0;
                end
                mcs_pkg::IDX_T1:   next_s.rdat = {20'h0, s.temp[0]};
                mcs_pkg::IDX_T2:   next_s.rdat = {20'h0, s.temp[1]};
                mcs_pkg::IDX_TI:   next_s.rdat = {20'h0, s.temp[2]};
                mcs_pkg::IDX_SEQ:  next_s.rdat = {26'h0, s.seqm};
                mcs_pkg::IDX_CFG:  next_s.rdat = {24'h0, s.cfg};
                mcs_pkg::IDX_PD:   next_s.rdat = {24'h0, s.pd};
                mcs_pkg::IDX_OFS1: next_s.rdat = {20'h0, s.ofs[0]};
                mcs_pkg::IDX_OFS2: next_s.rdat = {20'h0, s.ofs[1]};
                mcs_pkg::IDX_IST:  next_s.rdat = {28'h0, s.ist};
                mcs_pkg::IDX_IMSK: next_s.rdat = {28'h0, s.imsk};
                mcs_pkg::IDX_OCL:  next_s.rdat = {30'h0, s.oc};
                mcs_pkg::IDX_STAT: next_s.rdat = {27'h0, s.ref_rdy, s.cst == CV_BUSY, s.pend};
                default:           next_s.rdat = 32'h0;
            endcase
        end

        // Converter scheduling; temperature requests outrank any sequence slot
        case (s.cst)
            CV_IDLE: begin
                if (|s.pend) begin
                    t = s.pend[0] ? 2'h0 : (s.pend[1] ? 2'h1 : 2'h2);
                    next_s.pend[t] = 1'b0;
                    next_s.cur = mcs_pkg::CH_TEMP0 + 4'(t);
                    next_s.start = 1'b1;
                    next_s.cst = CV_BUSY;
                end else if (s.cfg[mcs_pkg::CFG_AUTO_BIT]) begin
                    nx = mcs_next({2'h0, s.seqm}, s.ptr);
                    if (nx[3]) begin
                        next_s.cur = {1'b0, nx[2:0]};
                        next_s.ptr = nx[2:0] + 3'h1;
                        next_s.start = 1'b1;
                        next_s.cst = CV_BUSY;
                    end
                end else if (s.cmd_mode && !s.wait_rd) begin
                    nx = mcs_next(s.cmd, s.ptr);
                    if (nx[3]) begin
                        next_s.ptr = nx[2:0] + 3'h1;
                        if (nx[2:0] >= 3'h6) begin
                            // Remote channel: latest automatic result, no conversion
                            next_s.res = {1'b0, nx[2:0], s.temp[nx[0]]};
                            next_s.wait_rd = 1'b1;
                            next_s.ist[mcs_pkg::IRQ_RES] = 1'b1;
                        end else begin
                            next_s.cur = {1'b0, nx[2:0]};
                            next_s.start = 1'b1;
                            next_s.cst = CV_BUSY;
                        end
                    end
                end
            end
            CV_BUSY: begin
                if (i_conv_done) begin
                    // Returning to idle lets a waiting request win the very next slot
                    next_s.cst = CV_IDLE;
                    if (s.cur >= mcs_pkg::CH_TEMP0) begin
                        next_s.ist[mcs_pkg::IRQ_TEMP] = 1'b1;
                        if (s.cur == mcs_pkg::CH_TINT) begin
                            next_s.temp[2] = i_conv_data;
                        end else begin
                            next_s.temp[s.cur[0]] = i_conv_data + s.ofs[s.cur[0]];
                        end
                    end else begin
                        next_s.res = {1'b0, s.cur[2:0], i_conv_data};
                        next_s.ist[mcs_pkg::IRQ_RES] = 1'b1;
                        next_s.wait_rd = s.cmd_mode & ~s.cfg[mcs_pkg::CFG_AUTO_BIT];
                    end
                end
            end
            default: next_s.cst = CV_IDLE;
        endcase
        next_s.pend = next_s.pend | integ_done;

        // Clear first, then set, so a flag raised in the clearing cycle survives
        next_s.oc = (s.oc & ~oc_clr) | s.sync2;
        for (int k = 0; k < 2; k++) begin
            if (s.sync2[k]) begin
                next_s.ist[mcs_pkg::IRQ_OC0 + k] = 1'b1;
            end
        end
        next_s.irq = |(next_s.ist & next_s.imsk);
        next_s.ref_en = ~next_s.pd[mcs_pkg::PD_DAC_REF:mcs_pkg::PD_ADC_REF];

        // Settling count restarts whenever either internal reference is off
        if (s.pd[mcs_pkg::PD_ADC_REF] || s.pd[mcs_pkg::PD_DAC_REF]) begin
            next_s.ref_cnt = 10'h0;
            next_s.ref_rdy = 1'b0;
        end else if (s.ref_cnt == 10'(mcs_pkg::REF_SETTLE_CYC)) begin
            next_s.ref_rdy = 1'b1;
        end else begin
            next_s.ref_cnt = s.ref_cnt + 10'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s <= '0;
            s.pd <= mcs_pkg::PD_RST;
            s.dac <= {4{mcs_pkg::DAC_RST}};
        end else begin
            s <= next_s;
        end
    end

    assign o_wb_dat               = s.rdat;
    assign o_wb_ack               = s.ack;
    assign o_overcurrent_flag_out = s.oc;
    assign o_conv                 = '{start: s.start, chan: s.cur};
    assign o_dac_tap              = s.dac;
    assign o_int_ref_adc_en       = s.ref_en[0];
    assign o_int_ref_dac_en       = s.ref_en[1];
    assign o_ref_ready            = s.ref_rdy;
    assign o_irq                  = s.irq;

    // ****************************************
    // Checks
    // ****************************************
    chk_idle_start_now: assert property (@(posedge i_clk) disable iff (i_reset)
        (s.cst == CV_IDLE && |s.pend) |=> (s.start && s.cur >= mcs_pkg::CH_TEMP0))
        else $error("Idle converter did not start pending temperature");
    chk_fixed_order: assert property (@(posedge i_clk) disable iff (i_reset)
        (s.cst == CV_IDLE && s.pend[0]) |=> s.cur == mcs_pkg::CH_TEMP0)
        else $error("Lowest temperature channel not served first");
    chk_keep_pending: assert property (@(posedge i_clk) disable iff (i_reset)
        (s.pend[1] && !(s.cst == CV_IDLE && !s.pend[0])) |=> s.pend[1])
        else $error("Pending request lost before its start");
    chk_after_done: assert property (@(posedge i_clk) disable iff (i_reset)
        (s.cst == CV_BUSY && i_conv_done && |s.pend) |=> ##1 (s.start && s.cur >= mcs_pkg::CH_TEMP0))
        else $error("Temperature not run right after current conversion");
    chk_auto_insert: assert property (@(posedge i_clk) disable iff (i_reset)
        (s.cfg[mcs_pkg::CFG_AUTO_BIT] && s.cst == CV_IDLE && |s.pend && |s.seqm) |=> s.cur[3:1] >= 3'h3)
        else $error("Autocycle slot not given to pending temperature");
    chk_integ_request: assert property (@(posedge i_clk) disable iff (i_reset)
        integ_done[1] |=> s.pend[1])
        else $error("Integration end raised no request");
    chk_offset_add: assert property (@(posedge i_clk) disable iff (i_reset)
        (s.cst == CV_BUSY && i_conv_done && s.cur == mcs_pkg::CH_TEMP0)
        |=> s.temp[0] == 12'($past(i_conv_data) + $past(s.ofs[0])))
        else $error("Remote offset not applied");
    chk_temp_read: assert property (@(posedge i_clk) disable iff (i_reset)
        (rd && idx == mcs_pkg::IDX_T2) |=> (o_wb_ack && o_wb_dat[11:0] == $past(s.temp[1])))
        else $error("Temperature register read wrong");
    chk_oc_set: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(i_oc_cmp[0]) |-> ##3 o_overcurrent_flag_out[0])
        else $error("Overcurrent flag not raised");
    chk_oc_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_overcurrent_flag_out[1] && !oc_clr[1]) |=> o_overcurrent_flag_out[1])
        else $error("Overcurrent flag dropped without clear");
    chk_dac_invert: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr && idx == mcs_pkg::IDX_RES && i_wb_sel[1:0] == 2'h3) |=> o_dac_tap[0] == ~$past(i_wb_dat[11:0]))
        else $error("DAC code not inverted");
    chk_ref_enable: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(o_int_ref_dac_en) |-> $past(wr && idx == mcs_pkg::IDX_PD))
        else $error("Internal reference enabled without power-down write");
    chk_remote_no_conv: assert property (@(posedge i_clk) disable iff (i_reset)
        ($rose(s.wait_rd) && $past(s.cst) == CV_IDLE) |-> (!s.start && s.res[14:13] == 2'h3))
        else $error("Remote command entry started a conversion");
    chk_reset_clear: assert property (@(posedge i_clk) i_reset |-> s.pend == 3'h0)
        else $error("Requests pending during reset");
    cov_auto_temp: cover property (@(posedge i_clk) disable iff (i_reset)
        s.cfg[mcs_pkg::CFG_AUTO_BIT] && s.start && s.cur >= mcs_pkg::CH_TEMP0);
    cov_cmd_remote: cover property (@(posedge i_clk) disable iff (i_reset) $rose(s.wait_rd) && s.res[14]);
    cov_oc_clear: cover property (@(posedge i_clk) disable iff (i_reset) $fell(o_overcurrent_flag_out[0]));
endmodule : mcs_top

// ### verification/mcs_conv_model.sv
// Purpose: Behavioural converter core facing the scheduler
// Assumes: One conversion at a time, same clock as the scheduler
// Notes:   Result is 0xA0 with the channel number in the low nibble
`timescale 1ns/100ps
module mcs_conv_model #(
    parameter int LAT = 3
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_start,
    input  wire logic [3:0]  i_chan,
    output logic             o_done,
    output logic      [11:0] o_data
);
    int cnt;
    // ****************************************
    // Conversion timing
    // ****************************************
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt    <= 0;
            o_done <= 1'b0;
            o_data <= 12'h000;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                cnt <= LAT;
            end else if (cnt == 1) begin
                cnt    <= 0;
                o_done <= 1'b1;
                o_data <= {8'hA0, i_chan};
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end else begin
                // Idle data toggles so a stale sample never looks valid
                o_data <= ~o_data;
            end
        end
    end
endmodule : mcs_conv_model

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the conversion scheduler
// Assumes: PERIOD_CYC of 300, so one temperature channel every 100 cycles
// Notes:   Bus requests change after a rising edge and are released at the edge that samples ack
`timescale 1ns/100ps
module tb_top;
    logic                   clk;
    logic                   rst;
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [3:0]             sel;
    logic [7:0]             adr;
    logic [31:0]            wdat;
    logic [31:0]            rdat;
    logic                   ack;
    logic [1:0]             oc_cmp;
    logic [1:0]             oc_flag;
    mcs_pkg::mcs_conv_req_t conv;
    logic                   done;
    logic [11:0]            cdat;
    logic [3:0][11:0]       tap;
    logic                   ref_adc;
    logic                   ref_dac;
    logic                   ref_rdy;
    logic                   irq;
    logic [31:0]            q;
    int                     fail_count;
    int                     comparisons;
    int                     n;

    mcs_top #(.PERIOD_CYC(300)) u_dut (.i_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_oc_cmp(oc_cmp), .o_overcurrent_flag_out(oc_flag), .o_conv(conv), .i_conv_done(done),
        .i_conv_data(cdat), .o_dac_tap(tap), .o_int_ref_adc_en(ref_adc), .o_int_ref_dac_en(ref_dac),
        .o_ref_ready(ref_rdy), .o_irq(irq));
    mcs_conv_model #(.LAT(3)) u_conv (.i_clk(clk), .i_reset(rst), .i_start(conv.start),
        .i_chan(conv.chan), .o_done(done), .o_data(cdat));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****************************************
    // Bench tasks
    // ****************************************
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic tmo();
        $display("FAIL %0t wait ran out", $time);
        fail_count++;
        close_out();
    endtask : tmo

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cycles(input int k);
        repeat (k) @(posedge clk);
    endtask : cycles

    // Holds the request until a rising edge samples ack high, takes read data and releases there
    task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        int m = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'hF;
        adr  <= {idx, 2'b00};
        wdat <= d;
        do begin
            @(posedge clk);
            m++;
        end while (ack !== 1'b1 && m < 20);
        if (m >= 20) tmo();
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    initial begin
        cycles(5000);
        tmo();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {cyc, stb, we, sel, adr, wdat, oc_cmp} = '0;
        rst = 1'b1;
        fail_count = 0;
        comparisons = 0;
        cycles(20);
        rst <= 1'b0;
        wb(1'b0, mcs_pkg::IDX_STAT, 32'h0);
        chk(q, 32'h0000_0000, "status after reset");
        wb(1'b0, mcs_pkg::IDX_PD, 32'h0);
        chk(q, 32'h0000_0030, "power-down reset");
        chk({30'h0, ref_adc, ref_dac}, 32'h0, "refs external");
        wb(1'b1, 6'h3F, 32'h0000_00FF);
        wb(1'b0, 6'h3F, 32'h0);
        chk(q, 32'h0, "unmapped read");
        wb(1'b1, mcs_pkg::IDX_IMSK, 32'h1);
        wb(1'b1, mcs_pkg::IDX_OFS1, 32'h0000_0010);
        wb(1'b1, mcs_pkg::IDX_OFS2, 32'h0000_0FFF);
        cycles(330);
        wb(1'b0, mcs_pkg::IDX_T1, 32'h0);
        chk(q, 32'h0000_0A16, "remote1 plus offset");
        wb(1'b0, mcs_pkg::IDX_T2, 32'h0);
        chk(q, 32'h0000_0A06, "remote2 minus one");
        wb(1'b0, mcs_pkg::IDX_TI, 32'h0);
        chk(q, 32'h0000_0A08, "internal temp");
        chk({31'h0, irq}, 32'h1, "irq raised");
        wb(1'b1, mcs_pkg::IDX_IMSK, 32'h0);
        cycles(2);
        chk({31'h0, irq}, 32'h0, "irq masked");
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (conv.start !== 1'b1 && n < 200);
        if (n >= 200) tmo();
        cycles(10);
        wb(1'b1, mcs_pkg::IDX_IST, 32'h1);
        wb(1'b0, mcs_pkg::IDX_IST, 32'h0);
        chk(q & 32'h1, 32'h0, "status cleared");
        for (int i = 0; i < 4; i++) begin
            chk({20'h0, tap[i]}, 32'h0000_0FFF, "dac reset");
            wb(1'b1, 6'(mcs_pkg::IDX_RES + i), 32'h0000_0123 + 32'(i));
            cycles(2);
            chk({20'h0, tap[i]}, 32'h0000_0EDC - 32'(i), "dac inverted");
        end
        oc_cmp <= 2'b01;
        cycles(5);
        oc_cmp <= 2'b00;
        cycles(5);
        chk({30'h0, oc_flag}, 32'h1, "overcurrent latched");
        wb(1'b0, mcs_pkg::IDX_OCL, 32'h0);
        chk(q, 32'h1, "latch readback");
        wb(1'b1, mcs_pkg::IDX_OCL, 32'h1);
        cycles(2);
        chk({30'h0, oc_flag}, 32'h0, "latch cleared");
        wb(1'b1, mcs_pkg::IDX_CMD, 32'h0000_0041);
        cycles(30);
        wb(1'b0, mcs_pkg::IDX_RES, 32'h0);
        chk(q, 32'h0000_0A00, "command result");
        cycles(20);
        wb(1'b0, mcs_pkg::IDX_RES, 32'h0);
        chk(q, 32'h0000_6A16, "remote entry in sequence");
        wb(1'b1, mcs_pkg::IDX_PD, 32'h0);
        cycles(2);
        chk({30'h0, ref_adc, ref_dac}, 32'h3, "refs internal");
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ref_rdy !== 1'b1 && n < 700);
        chk(32'(n >= 590 && n <= 610), 32'h1, "settle time");
        wb(1'b0, mcs_pkg::IDX_STAT, 32'h0);
        chk(q & 32'h10, 32'h10, "ready status");
        wb(1'b1, mcs_pkg::IDX_SEQ, 32'h1);
        wb(1'b1, mcs_pkg::IDX_CFG, 32'h1);
        wb(1'b1, mcs_pkg::IDX_OFS1, 32'h0000_0020);
        cycles(350);
        wb(1'b0, mcs_pkg::IDX_T1, 32'h0);
        chk(q, 32'h0000_0A26, "temp during autocycle");
        wb(1'b1, mcs_pkg::IDX_CFG, 32'h0);
        close_out();
    end
endmodule : tb_top
